// ---- src/pss_top.sv ----
// Purpose: Parameter save/restore command block with AHB-Lite registers
// Assumes: Storage engine answers each request with one nvm_done pulse
// Notes:   Command writes while an operation runs are stalled on the bus
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
import pss_pkg::*;

// Operation
// - Writing the save word into a save entry commits that category.
// - On save completion the entry is overwritten with 1.
// - Save entry 1 is all; 2..6 are comm, app, customer, drive, tuning.
// - Writing the discard word into a discard entry erases that category.
// - Discard-all spares tuning; tuning erased only through entry 6.
// - After a discard erase the device restarts by itself.
// - Marker holds date/time and is saved with save-all.
// - Writing any savable object, save entries 2..6 included, clears marker.
// - User memory gives eight 16-bit persistable values at entries 2..9.
// - Writing 1 to user entry 1 saves them; returns to 0 when done.
// - Only whole categories are stored; no single-object save.
// - Objects without a category are never stored.
module pss_top #(
    parameter int RESTART_LEN = RESTART_CYC
) (
    input  wire logic                     sys_clk,
    input  wire logic                     nrst,
    input  wire logic                     hsel,
    input  wire logic [pss_pkg::ADDR_W-1:0] haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic      [31:0]              hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    input  wire logic                     obj_wr,
    output logic                          nvm_start,
    output pss_pkg::pss_nvm_req_t         nvm_req,
    input  wire logic                     nvm_done,
    output logic      [63:0]              nvm_marker,
    output logic      [127:0]             nvm_user,
    output logic                          restart,
    output logic                          irq
);
    import pss_pkg::*;

    typedef enum logic {
        ST_IDLE,
        ST_BUSY
    } pss_state_t;

    // Bus data phase
    logic              dp_valid_q;
    logic              dp_write_q;
    logic [ADDR_W-1:0] dp_addr_q;
    logic              rd_done_q;
    logic [31:0]       hrdata_q;
    logic [31:0]       rd_mux;

    // Dictionary entries
    logic [31:0]       save_q   [1:6];
    logic [31:0]       disc_q   [1:6];
    logic [31:0]       mark_q   [1:2];
    logic [15:0]       usr_q    [1:NUSR];
    logic [15:0]       usr_trg_q;

    // Operation control
    pss_state_t        state_q;
    pss_op_t           op_q;
    logic [3:0]        op_sub_q;
    logic              nvm_start_q;
    pss_nvm_req_t      nvm_req_q;
    logic              restart_go_q;
    logic [NEVT-1:0]   evt_q;
    logic [NEVT-1:0]   irq_status;
    logic [NEVT-1:0]   irq_mask;

    // Decode
    wire               addr_ph  = hsel & htrans[1] & hready;
    wire [OBJ_W-1:0]   dp_obj   = dp_addr_q[ADDR_W-1:SUB_W+2];
    wire [SUB_W-1:0]   dp_sub   = dp_addr_q[SUB_W+1:2];
    wire               sub_cat  = (dp_sub >= SUB_ALL) && (dp_sub <= SUB_TUNING);
    wire               is_save  = (dp_obj == OBJ_SAVE) && sub_cat;
    wire               is_disc  = (dp_obj == OBJ_DISCARD) && sub_cat;
    wire               is_mark  = (dp_obj == OBJ_MARKER)
                                  && (dp_sub >= SUB_MRK_LO) && (dp_sub <= SUB_MRK_HI);
    wire               is_utrg  = (dp_obj == OBJ_USER) && (dp_sub == SUB_USR_TRG);
    wire               is_uval  = (dp_obj == OBJ_USER)
                                  && (dp_sub >= SUB_USR_LO) && (dp_sub <= SUB_USR_HI);
    wire               is_ist   = (dp_obj == OBJ_IRQ) && (dp_sub == SUB_IRQ_ST);
    wire               is_imsk  = (dp_obj == OBJ_IRQ) && (dp_sub == SUB_IRQ_MSK);
    wire               is_cmd   = is_save | is_disc | is_utrg;
    wire               busy     = (state_q == ST_BUSY);
    wire               dp_rd    = dp_valid_q & ~dp_write_q;
    // Stall command writes until the running operation has ended
    wire               wr_hold  = dp_valid_q & dp_write_q & is_cmd & busy;
    wire               wr_fire  = dp_valid_q & dp_write_q & ~wr_hold;
    wire [3:0]         usr_idx  = dp_sub - SUB_ALL;

    // Commands only start on the exact word
    wire               save_go  = wr_fire & is_save & (hwdata == SAVE_WORD);
    wire               disc_go  = wr_fire & is_disc & (hwdata == DISC_WORD);
    wire               user_go  = wr_fire & is_utrg & (hwdata[15:0] == USR_GO);
    wire               bad_cmd  = wr_fire & ((is_save & (hwdata != SAVE_WORD))
                                  | (is_disc & (hwdata != DISC_WORD)));
    // Save entries 2..6 are savable objects; entry 1 and the marker are not
    wire               mark_clr = obj_wr | (wr_fire & is_save & (dp_sub != SUB_ALL));
    wire               op_end   = busy & nvm_done;

    // Category masks carry only the five categories
    wire [4:0]         sel_cat  = (dp_sub == SUB_ALL) ? CAT_ALL
                                  : (CAT_ONE << (dp_sub - 4'h2));
    wire [4:0]         disc_cat = (dp_sub == SUB_ALL) ? CAT_NO_TUNE : sel_cat;

    assign hreadyout  = ~dp_valid_q | (dp_write_q ? ~wr_hold : rd_done_q);
    assign hresp      = 1'b0;
    assign hrdata     = hrdata_q;
    assign nvm_start  = nvm_start_q;
    assign nvm_req    = nvm_req_q;
    assign nvm_marker = {mark_q[2], mark_q[1]};

    genvar gi;
    generate
        for (gi = 1; gi <= NUSR; gi++) begin : g_usr_out
            assign nvm_user[gi*16-1 -: 16] = usr_q[gi];
        end
    endgenerate

    // Read selection, unmapped reads as zero
    always_comb begin
        rd_mux = '0;
        if (is_save) begin
            rd_mux = save_q[dp_sub[2:0]];
        end else if (is_disc) begin
            rd_mux = disc_q[dp_sub[2:0]];
        end else if (is_mark) begin
            rd_mux = mark_q[dp_sub[1:0]];
        end else if (is_utrg) begin
            rd_mux = {16'h0000, usr_trg_q};
        end else if (is_uval) begin
            rd_mux = {16'h0000, usr_q[usr_idx]};
        end else if (is_ist) begin
            rd_mux = {{(32-NEVT){1'b0}}, irq_status};
        end else if (is_imsk) begin
            rd_mux = {{(32-NEVT){1'b0}}, irq_mask};
        end
    end

    // Bus phases; reads take one wait state so data come from a flop
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q  <= '0;
            rd_done_q  <= 1'b0;
            hrdata_q   <= '0;
        end else begin
            if (addr_ph && hreadyout) begin
                dp_valid_q <= 1'b1;
                dp_write_q <= hwrite;
                dp_addr_q  <= haddr;
            end else if (hreadyout) begin
                dp_valid_q <= 1'b0;
            end
            rd_done_q <= dp_rd & ~rd_done_q;
            if (dp_rd && !rd_done_q) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // Save and discard entries
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            for (int i = 1; i <= 6; i++) begin
                save_q[i] <= CMD_RST;
                disc_q[i] <= CMD_RST;
            end
        end else begin
            if (wr_fire && is_save) begin
                save_q[dp_sub[2:0]] <= hwdata;
            end
            if (wr_fire && is_disc) begin
                disc_q[dp_sub[2:0]] <= hwdata;
            end
            if (op_end && op_q == OP_SAVE) begin
                save_q[op_sub_q[2:0]] <= CMD_DONE;
            end
        end
    end

    // Marker and user memory
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            mark_q[1] <= MARK_CLR;
            mark_q[2] <= MARK_CLR;
            usr_trg_q <= USR_IDLE;
            for (int i = 1; i <= NUSR; i++) begin
                usr_q[i] <= USR_RST;
            end
        end else begin
            if (mark_clr) begin
                mark_q[1] <= MARK_CLR;
                mark_q[2] <= MARK_CLR;
            end
            if (wr_fire && is_mark) begin
                mark_q[dp_sub[1:0]] <= hwdata;
            end
            if (wr_fire && is_uval) begin
                usr_q[usr_idx] <= hwdata[15:0];
            end
            if (user_go) begin
                usr_trg_q <= USR_GO;
            end else if (op_end && op_q == OP_USER) begin
                usr_trg_q <= USR_IDLE;
            end
        end
    end

    // One operation at a time toward the storage engine
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_q      <= ST_IDLE;
            op_q         <= OP_SAVE;
            op_sub_q     <= '0;
            nvm_start_q  <= 1'b0;
            nvm_req_q    <= '{op: OP_SAVE, cat: CAT_NONE, with_marker: 1'b0};
            restart_go_q <= 1'b0;
            evt_q        <= '0;
        end else begin
            nvm_start_q  <= 1'b0;
            restart_go_q <= 1'b0;
            evt_q        <= '0;
            evt_q[EVT_BADCMD] <= bad_cmd;
            unique case (state_q)
                ST_IDLE: begin
                    if (save_go || disc_go || user_go) begin
                        state_q     <= ST_BUSY;
                        op_sub_q    <= dp_sub;
                        nvm_start_q <= 1'b1;
                        if (save_go) begin
                            op_q      <= OP_SAVE;
                            nvm_req_q <= '{op: OP_SAVE, cat: sel_cat,
                                           with_marker: (dp_sub == SUB_ALL)};
                        end else if (disc_go) begin
                            op_q      <= OP_DISCARD;
                            nvm_req_q <= '{op: OP_DISCARD, cat: disc_cat,
                                           with_marker: 1'b0};
                        end else begin
                            op_q      <= OP_USER;
                            nvm_req_q <= '{op: OP_USER, cat: CAT_NONE,
                                           with_marker: 1'b0};
                        end
                    end
                end
                ST_BUSY: begin
                    if (nvm_done) begin
                        state_q <= ST_IDLE;
                        evt_q[EVT_SAVE] <= (op_q == OP_SAVE);
                        evt_q[EVT_DISC] <= (op_q == OP_DISCARD);
                        evt_q[EVT_USER] <= (op_q == OP_USER);
                        // Erase done: restart with no further command
                        restart_go_q <= (op_q == OP_DISCARD);
                    end
                end
            endcase
        end
    end

    pss_restart #(
        .LEN     (RESTART_LEN)
    ) u_restart (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .go      (restart_go_q),
        .restart (restart)
    );

    pss_evt_irq #(
        .N       (NEVT)
    ) u_irq (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .evt     (evt_q),
        .st_wr   (wr_fire & is_ist),
        .msk_wr  (wr_fire & is_imsk),
        .wdata   (hwdata[NEVT-1:0]),
        .status  (irq_status),
        .mask    (irq_mask),
        .irq     (irq)
    );

endmodule : pss_top

// ---- src/pss_pkg.sv ----
// Purpose: Shared constants and types of the parameter save/restore block
// Assumes: Registers reached over AHB-Lite, 32-bit words
// Notes:   Entry byte address = ((object << 4) | subindex) << 2
package pss_pkg;

    localparam int          ADDR_W      = 20;
    localparam int          OBJ_W       = 14;
    localparam int          SUB_W       = 4;
    localparam int          NCAT        = 5;
    localparam int          NEVT        = 4;
    localparam int          NUSR        = 8;

    // Object indices as printed
    localparam logic [13:0] OBJ_SAVE    = 14'h1010;
    localparam logic [13:0] OBJ_DISCARD = 14'h1011;
    localparam logic [13:0] OBJ_MARKER  = 14'h1020;
    localparam logic [13:0] OBJ_USER    = 14'h2700;
    localparam logic [13:0] OBJ_IRQ     = 14'h3F00;

    localparam logic [3:0]  SUB_ALL     = 4'h1;
    localparam logic [3:0]  SUB_TUNING  = 4'h6;
    localparam logic [3:0]  SUB_MRK_LO  = 4'h1;
    localparam logic [3:0]  SUB_MRK_HI  = 4'h2;
    localparam logic [3:0]  SUB_USR_TRG = 4'h1;
    localparam logic [3:0]  SUB_USR_LO  = 4'h2;
    localparam logic [3:0]  SUB_USR_HI  = 4'h9;
    localparam logic [3:0]  SUB_IRQ_ST  = 4'h0;
    localparam logic [3:0]  SUB_IRQ_MSK = 4'h1;

    localparam logic [31:0] SAVE_WORD   = 32'h65766173;
    localparam logic [31:0] DISC_WORD   = 32'h64616F6C;
    localparam logic [31:0] CMD_DONE    = 32'h00000001;
    localparam logic [31:0] CMD_RST     = 32'h00000000;
    localparam logic [31:0] MARK_CLR    = 32'h00000000;
    localparam logic [15:0] USR_GO      = 16'h0001;
    localparam logic [15:0] USR_IDLE    = 16'h0000;
    localparam logic [15:0] USR_RST     = 16'h0000;

    // Category mask bits: comm, app, customer, drive, tuning
    localparam logic [4:0]  CAT_ALL     = 5'h1F;
    localparam logic [4:0]  CAT_NO_TUNE = 5'h0F;
    localparam logic [4:0]  CAT_NONE    = 5'h00;
    localparam logic [4:0]  CAT_ONE     = 5'h01;

    localparam int          EVT_SAVE    = 0;
    localparam int          EVT_DISC    = 1;
    localparam int          EVT_USER    = 2;
    localparam int          EVT_BADCMD  = 3;

    localparam int          RESTART_CYC = 16;

    typedef enum logic [1:0] {
        OP_SAVE,
        OP_DISCARD,
        OP_USER
    } pss_op_t;

    typedef struct packed {
        pss_op_t    op;
        logic [4:0] cat;
        logic       with_marker;
    } pss_nvm_req_t;

endpackage : pss_pkg

// ---- src/pss_evt_irq.sv ----
// Purpose: Sticky event status, mask and one level interrupt
// Assumes: Status cleared by writing one; set wins over clear
// Notes:   Mask has the status layout
`timescale 1ns/1ps
module pss_evt_irq #(
    parameter int N = 4
) (
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire logic [N-1:0] evt,
    input  wire logic         st_wr,
    input  wire logic         msk_wr,
    input  wire logic [N-1:0] wdata,
    output logic      [N-1:0] status,
    output logic      [N-1:0] mask,
    output logic              irq
);
    logic [N-1:0] st_q;
    logic [N-1:0] st_d;
    logic [N-1:0] msk_q;

    // New event beats a simultaneous clear
    assign st_d   = evt | (st_q & ~(st_wr ? wdata : '0));
    assign status = st_q;
    assign mask   = msk_q;
    assign irq    = |(st_q & msk_q);

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_q  <= '0;
            msk_q <= '0;
        end else begin
            st_q  <= st_d;
            if (msk_wr) begin
                msk_q <= wdata;
            end
        end
    end
endmodule : pss_evt_irq

// ---- src/pss_restart.sv ----
// Purpose: Stretches a restart request into a fixed-length level
// Assumes: Request is a one-cycle pulse
// Notes:   Length counts clock cycles
`timescale 1ns/1ps
module pss_restart #(
    parameter int LEN = 16
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic go,
    output logic      restart
);
    localparam int CW = $clog2(LEN + 1);
    localparam logic [CW-1:0] LEN_C = CW'(LEN);

    logic [CW-1:0] cnt_q;

    assign restart = (cnt_q != '0);

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else if (go) begin
            cnt_q <= LEN_C;
        end else if (restart) begin
            cnt_q <= cnt_q - CW'(1);
        end
    end
endmodule : pss_restart

// ---- testbench/pss_props.sv ----
// Purpose: Port-level checks of the parameter save/restore block
// Assumes: One clock domain; hready is the slave's own hreadyout
// Notes:   Bound to pss_top after the module
`timescale 1ns/1ps
module pss_props
    import pss_pkg::*;
#(
    parameter int RESTART_LEN = 16
) (
    input wire logic                     sys_clk,
    input wire logic                     nrst,
    input wire logic                     hsel,
    input wire logic [pss_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0]               htrans,
    input wire logic                     hwrite,
    input wire logic [31:0]              hwdata,
    input wire logic                     hready,
    input wire logic                     hreadyout,
    input wire logic                     hresp,
    input wire logic                     obj_wr,
    input wire logic                     nvm_start,
    input wire pss_pkg::pss_nvm_req_t    nvm_req,
    input wire logic                     nvm_done,
    input wire logic [63:0]              nvm_marker,
    input wire logic                     restart
);
    logic        dph_q, wr_q, busy_q, disc_q;
    logic [19:0] a_q;
    logic [4:0]  cat_q;
    logic [7:0]  rcnt_q;

    wire         take    = hsel && htrans[1] && hready && hreadyout;
    wire [13:0]  obj     = a_q[19:6];
    wire [3:0]   sub     = a_q[5:2];
    wire         wr_now  = dph_q && wr_q && hreadyout;
    wire         is_disc = obj == OBJ_DISCARD;
    wire         is_cmd  = (obj == OBJ_SAVE || is_disc) && sub >= SUB_ALL && sub <= SUB_TUNING;
    wire [31:0]  word    = is_disc ? DISC_WORD : SAVE_WORD;
    wire [4:0]   cat     = (sub == SUB_ALL) ? (is_disc ? CAT_NO_TUNE : CAT_ALL)
                                            : 5'(CAT_ONE << (sub - 4'h2));
    wire         mrk_now = wr_now && obj == OBJ_MARKER;
    wire         clr_src = obj_wr || (wr_now && is_cmd && !is_disc && sub != SUB_ALL);

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            dph_q  <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            if (hready) dph_q <= take;
            if (nvm_start) busy_q <= 1'b1;
            else if (nvm_done) busy_q <= 1'b0;
        end
    end

    // Kept one cycle for comparison after the edge
    always_ff @(posedge sys_clk) begin
        if (hready && take) {a_q, wr_q} <= {haddr, hwrite};
        cat_q  <= cat;
        disc_q <= is_disc;
        rcnt_q <= restart ? rcnt_q + 8'h01 : 8'h00;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_okay; hresp == 1'b0; endproperty
    property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    property p_start;
        wr_now && is_cmd && hwdata == word |=> nvm_start && nvm_req.cat == cat_q
            && nvm_req.op == (disc_q ? OP_DISCARD : OP_SAVE);
    endproperty
    property p_bad; wr_now && is_cmd && hwdata != word |=> !nvm_start; endproperty
    property p_pulse; nvm_start |=> !nvm_start; endproperty
    property p_hold; nvm_start |-> !busy_q; endproperty
    property p_marker;
        nvm_start && nvm_req.op == OP_SAVE |-> nvm_req.with_marker == (nvm_req.cat == CAT_ALL);
    endproperty
    property p_clr; clr_src && !mrk_now |=> nvm_marker == 64'h0; endproperty
    property p_rst_go; busy_q && nvm_done && nvm_req.op == OP_DISCARD |=> ##[0:1] restart;
    endproperty
    property p_rst_len; $fell(restart) |-> rcnt_q == RESTART_LEN; endproperty

    a_okay:    assert property (p_okay) else $error("hresp not OKAY");
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    a_start:   assert property (p_start) else $error("command did not start op");
    a_bad:     assert property (p_bad) else $error("bad command started op");
    a_pulse:   assert property (p_pulse) else $error("start longer than a cycle");
    a_hold:    assert property (p_hold) else $error("start while busy");
    a_marker:  assert property (p_marker) else $error("marker flag wrong");
    a_clr:     assert property (p_clr) else $error("marker not cleared");
    a_rst_go:  assert property (p_rst_go) else $error("no restart after discard");
    a_rst_len: assert property (p_rst_len) else $error("restart length wrong");

    c_all:   cover property (nvm_start && nvm_req.cat == CAT_ALL);
    c_rst:   cover property ($rose(restart));
    c_stall: cover property (busy_q && !hreadyout && dph_q && wr_q);
endmodule : pss_props

bind pss_top pss_props #(
    .RESTART_LEN(RESTART_LEN)
) u_props (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .obj_wr(obj_wr), .nvm_start(nvm_start), .nvm_req(nvm_req),
    .nvm_done(nvm_done), .nvm_marker(nvm_marker), .restart(restart)
);

// ---- testbench/pss_nvm_model.sv ----
// Purpose: Behavioural storage engine answering each request once
// Assumes: Requests are single-cycle pulses
// Notes:   Slow mode stands in for saves lasting seconds
`timescale 1ns/1ps
module pss_nvm_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic nvm_start,
    input wire logic slow,
    output logic     nvm_done
);
    int   cnt;
    logic run;

    always @(posedge sys_clk) begin
        if (!nrst) begin
            run      <= 1'b0;
            nvm_done <= 1'b0;
        end else begin
            nvm_done <= 1'b0;
            if (nvm_start) begin
                run <= 1'b1;
                cnt <= slow ? 40 : 3;
            end else if (run) begin
                cnt <= cnt - 1;
                if (cnt == 1) begin
                    run      <= 1'b0;
                    nvm_done <= 1'b1;
                end
            end
        end
    end
endmodule : pss_nvm_model

// ---- testbench/pss_top_test.sv ----
// Purpose: Self-checking bench of the save/restore block
// Assumes: Bus driven as a single AHB-Lite master
// Notes:   Restart shortened to four cycles
`timescale 1ns/1ps
module pss_top_test;
    import pss_pkg::*;
    localparam int RLEN = 4;
    logic         sys_clk, nrst, hsel, hwrite, obj_wr, slow, rd_dph, rdy_n;
    logic [19:0]  haddr;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [31:0]  hwdata, hrdata, m1, m2, d;
    logic         hreadyout, hresp, nvm_start, nvm_done, restart, irq;
    wire logic    hready;
    pss_nvm_req_t nvm_req, e_req;
    logic [63:0]  nvm_marker;
    logic [127:0] nvm_user, uv;
    logic [7:0]   m_req;
    logic [31:0]  exp_rd[$];
    pss_nvm_req_t exp_req[$];
    int           n_mismatch, checked, seed, s;

    assign hready = hreadyout;

    pss_top #(.RESTART_LEN(RLEN)) dut (
        .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .obj_wr(obj_wr), .nvm_start(nvm_start),
        .nvm_req(nvm_req), .nvm_done(nvm_done), .nvm_marker(nvm_marker),
        .nvm_user(nvm_user), .restart(restart), .irq(irq)
    );
    pss_nvm_model u_nvm (
        .sys_clk(sys_clk), .nrst(nrst), .nvm_start(nvm_start), .slow(slow),
        .nvm_done(nvm_done)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    function automatic logic [19:0] ea(input logic [13:0] o, input logic [3:0] sb);
        return {o, sb, 2'b00};
    endfunction : ea

    task automatic chk(input string what, input logic [127:0] e, input logic [127:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", what, e, g);
        end
    endtask : chk

    task bus(input logic w, input logic [19:0] a, input logic [31:0] dt);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= a;
        do @(posedge sys_clk); while (rdy_n !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= dt;
        do @(posedge sys_clk); while (rdy_n !== 1'b1);
    endtask : bus

    task wr(input logic [19:0] a, input logic [31:0] dt);
        bus(1'b1, a, dt);
    endtask : wr

    task rd(input logic [19:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        bus(1'b0, a, ~e);
    endtask : rd

    task wait_done;
        for (int i = 0; i < 400; i++) begin
            @(negedge sys_clk);
            if (nvm_done === 1'b1) break;
        end
        @(posedge sys_clk);
    endtask : wait_done

    task end_of_test;
        $display("Checks %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // Sampled mid-cycle to avoid process-order races
    always @(negedge sys_clk) begin
        rdy_n = hreadyout;
        if (rd_dph && hreadyout === 1'b1) begin
            chk("hrdata", exp_rd.pop_front(), hrdata);
            rd_dph = 1'b0;
        end
        if (hsel && htrans[1] && !hwrite && hreadyout) rd_dph = 1'b1;
        if (nvm_start === 1'b1) begin
            e_req = exp_req.size() ? exp_req.pop_front() : 8'hFF;
            m_req = (e_req.op == OP_USER) ? 8'hC0 : (e_req.op == OP_DISCARD) ? 8'hFE : 8'hFF;
            chk("nvm_req", e_req & m_req, nvm_req & m_req);
        end
    end

    initial begin
        repeat (30000) @(posedge sys_clk);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        seed = 32'h7cce518a;
        {n_mismatch, checked, rd_dph, rdy_n} = '0;
        {nrst, hsel, htrans, hwrite, haddr, hwdata, obj_wr} = '0;
        hsize = 3'h2;
        slow  = 1'b1;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rd(ea(OBJ_SAVE, SUB_ALL), CMD_RST);
        rd(ea(OBJ_MARKER, SUB_MRK_LO), MARK_CLR);
        wr(20'h00100, $random(seed));
        rd(20'h00100, 32'h0);
        m1 = $random(seed);
        m2 = $random(seed);
        wr(ea(OBJ_MARKER, SUB_MRK_LO), m1);
        wr(ea(OBJ_MARKER, SUB_MRK_HI), m2);
        @(posedge sys_clk);
        chk("nvm_marker", {m2, m1}, nvm_marker);
        for (s = 1; s <= 6; s++) begin
            exp_req.push_back('{OP_SAVE, (s == 1) ? CAT_ALL : 5'(CAT_ONE << (s - 2)), s == 1});
            wr(ea(OBJ_SAVE, 4'(s)), SAVE_WORD);
            rd(ea(OBJ_SAVE, 4'(s)), SAVE_WORD);
            wait_done();
            @(posedge sys_clk);
            rd(ea(OBJ_SAVE, 4'(s)), CMD_DONE);
            rd(ea(OBJ_MARKER, SUB_MRK_LO), (s == 1) ? m1 : MARK_CLR);
        end
        rd(ea(OBJ_IRQ, SUB_IRQ_ST), 32'h1);
        wr(ea(OBJ_IRQ, SUB_IRQ_ST), 32'hF);
        rd(ea(OBJ_IRQ, SUB_IRQ_ST), 32'h0);
        wr(ea(OBJ_MARKER, SUB_MRK_LO), m1);
        obj_wr <= 1'b1;
        @(posedge sys_clk);
        obj_wr <= 1'b0;
        rd(ea(OBJ_MARKER, SUB_MRK_LO), MARK_CLR);
        // Second command must stall until the first finishes
        exp_req.push_back('{OP_SAVE, 5'h02, 1'b0});
        exp_req.push_back('{OP_SAVE, 5'h08, 1'b0});
        wr(ea(OBJ_SAVE, 4'h3), SAVE_WORD);
        wr(ea(OBJ_SAVE, 4'h5), SAVE_WORD);
        wait_done();
        @(posedge sys_clk);
        rd(ea(OBJ_SAVE, 4'h5), CMD_DONE);
        wr(ea(OBJ_IRQ, SUB_IRQ_MSK), 32'h8);
        d = $random(seed);
        if (d == SAVE_WORD) d = ~d;
        wr(ea(OBJ_SAVE, 4'h4), d);
        repeat (2) @(posedge sys_clk);
        chk("irq", 1'b1, irq);
        rd(ea(OBJ_IRQ, SUB_IRQ_ST), 32'h9);
        wr(ea(OBJ_IRQ, SUB_IRQ_MSK), 32'h0);
        @(posedge sys_clk);
        chk("irq", 1'b0, irq);
        wr(ea(OBJ_IRQ, SUB_IRQ_ST), 32'hF);
        rd(ea(OBJ_IRQ, SUB_IRQ_ST), 32'h0);
        slow <= 1'b0;
        for (s = 1; s <= 6; s++) begin
            exp_req.push_back('{OP_DISCARD, (s == 1) ? CAT_NO_TUNE : 5'(CAT_ONE << (s - 2)), 0});
            wr(ea(OBJ_DISCARD, 4'(s)), DISC_WORD);
            wait_done();
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            chk("restart", 1'b1, restart);
            repeat (RLEN + 2) @(posedge sys_clk);
        end
        rd(ea(OBJ_IRQ, SUB_IRQ_ST), 32'h2);
        for (s = 0; s < 8; s++) begin
            uv[16*s +: 16] = $random(seed);
            wr(ea(OBJ_USER, 4'(s + 2)), {16'hA5A5, uv[16*s +: 16]});
            rd(ea(OBJ_USER, 4'(s + 2)), {16'h0, uv[16*s +: 16]});
        end
        @(negedge sys_clk);
        chk("nvm_user", uv, nvm_user);
        slow <= 1'b1;
        exp_req.push_back('{OP_USER, CAT_NONE, 1'b0});
        wr(ea(OBJ_USER, SUB_USR_TRG), 32'(USR_GO));
        rd(ea(OBJ_USER, SUB_USR_TRG), 32'(USR_GO));
        wait_done();
        @(posedge sys_clk);
        rd(ea(OBJ_USER, SUB_USR_TRG), 32'(USR_IDLE));
        rd(ea(OBJ_IRQ, SUB_IRQ_ST), 32'h6);
        repeat (4) @(posedge sys_clk);
        chk("queues", 0, exp_rd.size() + exp_req.size());
        end_of_test();
    end
endmodule : pss_top_test
